// ==== hdl/boost_cfg_if.sv ====
// Carries switching settings to the phase generator and its clocks back.
// Both ends sit on the same clock.
interface boost_cfg_if;
	boost_pkg::boost_phase_e phase;
	logic [7:0]              div;
	logic [3:0]              clk;

	modport ctrl (output phase, output div, input clk);
	modport gen (input phase, input div, output clk);
endinterface

// ==== hdl/boost_phase_gen.sv ====
// Divides the clock into four boost switching clocks with selectable phase.
// Assumes div is even and at least four.
module boost_phase_gen (
	// Clock and reset
	input  wire logic  mclk_in,
	input  wire logic  reset_in,
	// Settings
	boost_cfg_if.gen   cfg
);

	logic [7:0] cnt_r;
	logic [3:0] clk_r;
	logic [7:0] half;
	logic [7:0] quarter;
	logic [7:0] off [4];

	function automatic logic shifted_high(input logic [7:0] c, input logic [7:0] o,
		input logic [7:0] n);
		logic [8:0] s;
		s = {1'b0, c} + {1'b0, o};
		if (s >= {1'b0, n}) begin
			s = s - {1'b0, n};
		end
		return s < {2'b00, n[7:1]};
	endfunction

	assign half    = {1'b0, cfg.div[7:1]};
	assign quarter = {2'b00, cfg.div[7:2]};

	always_comb begin
		off[0] = 8'h00;
		off[1] = 8'h00;
		off[2] = 8'h00;
		off[3] = 8'h00;
		case (cfg.phase)
			boost_pkg::PH_SAME: begin // [R7]
			end
			boost_pkg::PH_AB_CD: begin // [R8]
				off[2] = half;
				off[3] = half;
			end
			boost_pkg::PH_AC_BD: begin // [R9]
				off[1] = half;
				off[3] = half;
			end
			default: begin // [R10]
				off[1] = quarter;
				off[2] = half;
				off[3] = 8'(half + quarter);
			end
		endcase
	end

	// Wrap on >= so a shorter divider never lets the count run away
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			cnt_r <= 8'h00;
		end else if (cnt_r >= 8'(cfg.div - 8'h01)) begin // [R11]
			cnt_r <= 8'h00;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			clk_r <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				clk_r[i] <= shifted_high(cnt_r, off[i], cfg.div);
			end
		end
	end

	assign cfg.clk = clk_r;

	chk_phase_same: assert property (@(posedge mclk_in) disable iff (reset_in) // [R7]
		($past(cfg.phase) == boost_pkg::PH_SAME) |-> (clk_r == 4'h0 || clk_r == 4'hf))
		else $error("same-edge phase gives unequal clocks");

	// A divider change leaves the count past the new end for a cycle, so those cycles are skipped
	chk_phase_ab_cd: assert property (@(posedge mclk_in) disable iff (reset_in) // [R8]
		($past(cfg.phase) == boost_pkg::PH_AB_CD && $stable(cfg.div) && $past(cnt_r) < cfg.div)
		|-> (clk_r[1] == clk_r[0] && clk_r[2] == !clk_r[0] && clk_r[3] == !clk_r[0]))
		else $error("A/B against C/D phase wrong");

	chk_phase_ac_bd: assert property (@(posedge mclk_in) disable iff (reset_in) // [R9]
		($past(cfg.phase) == boost_pkg::PH_AC_BD && $stable(cfg.div) && $past(cnt_r) < cfg.div)
		|-> (clk_r[2] == clk_r[0] && clk_r[1] == !clk_r[0] && clk_r[3] == !clk_r[0]))
		else $error("A/C against B/D phase wrong");

	chk_phase_quad: assert property (@(posedge mclk_in) disable iff (reset_in) // [R10]
		($past(cfg.phase) == boost_pkg::PH_QUAD && $stable(cfg.div) && $past(cnt_r) < cfg.div)
		|-> (clk_r[2] == !clk_r[0] && clk_r[3] == !clk_r[1]))
		else $error("quadrature phase wrong");

	chk_div_wrap: assert property (@(posedge mclk_in) disable iff (reset_in) // [R11]
		(cnt_r == 8'(cfg.div - 8'h01) && $stable(cfg.div)) |=> (cnt_r == 8'h00))
		else $error("divider did not wrap at its terminal count");

endmodule

// ==== hdl/boost_pkg.sv ====
// Constants for the software command and boost converter control block.
// Assumes a single 40 MHz clock that stands in for the internal oscillator.
package boost_pkg;

	// Command word routing, top three bits of a 16-bit write
	localparam int         SEL_LSB   = 13;
	localparam logic [2:0] SEL_SW    = 3'h4;
	localparam logic [2:0] SEL_BOOST = 3'h3;

	// Software command register
	localparam int          CRC_EN_BIT      = 12;
	localparam logic [11:0] SOFT_RESET_CODE = 12'h555;
	localparam logic [11:0] KEEPALIVE_CODE  = 12'h195;

	// Boost control register fields and reset value
	localparam int         COMP_BIT    = 6;
	localparam int         PHASE_LSB   = 4;
	localparam int         FREQ_LSB    = 2;
	localparam int         LIMIT_LSB   = 0;
	localparam int         BOOST_W     = 7;
	localparam logic [6:0] BOOST_RESET = 7'h04;

	typedef enum logic [1:0] {
		PH_SAME,
		PH_AB_CD,
		PH_AC_BD,
		PH_QUAD
	} boost_phase_e;

	localparam logic [1:0] FREQ_250K = 2'h0;
	localparam logic [1:0] FREQ_410K = 2'h1;
	localparam logic [1:0] FREQ_650K = 2'h2;

	// Switching clock dividers, kept even so half-period shifts are exact
	localparam int         CLK_HZ     = 40_000_000;
	localparam int         F_250K_HZ  = 250_000;
	localparam int         F_410K_HZ  = 410_000;
	localparam int         F_650K_HZ  = 650_000;
	localparam logic [7:0] DIV_250K   = 8'((CLK_HZ / (2 * F_250K_HZ)) * 2);
	localparam logic [7:0] DIV_410K   = 8'((CLK_HZ / (2 * F_410K_HZ)) * 2);
	localparam logic [7:0] DIV_650K   = 8'((CLK_HZ / (2 * F_650K_HZ)) * 2);

	// Boost output limit in units of 100 mV
	localparam logic [8:0] LIMIT_23V0 = 9'h0e6;
	localparam logic [8:0] LIMIT_24V5 = 9'h0f5;
	localparam logic [8:0] LIMIT_27V0 = 9'h10e;
	localparam logic [8:0] LIMIT_29V5 = 9'h127;

	// Slew rate word: enable bit and seven setting bits
	localparam int SLEW_EN_BIT = 12;
	localparam int SLEW_CFG_W  = 7;

	// Watchdog
	localparam int WDOG_TIMEOUT_US_DFLT = 5000;
	localparam int US_CYCLES            = CLK_HZ / 1_000_000;

endpackage

// ==== hdl/sw_boost_ctrl.sv ====
// Software command and boost converter control registers.
// Assumes the serial front end hands over whole 16-bit words, one per strobe.
//
// Summary of operation
// [R1] Bit 12 of software write sets CRC checking
// [R2] Low bits 0x555 fully reset the block; the phase generator counter and clocks are not reset and keep running
// [R3] Host sends 0x195 before each watchdog timeout
// [R4] Missed keep-alive raises the alert output
// [R5] Boost word: comp, phase, frequency, limit fields
// [R6] Comp bit 0 internal resistor, 1 bypass
// [R7] Phase 00 clocks all channels together
// [R8] Phase 01 splits A,B from C,D
// [R9] Phase 10 splits A,C from B,D
// [R10] Phase 11 clocks channels in quadrature
// [R11] Frequency codes select divided switching clocks
// [R12] Limit code selects maximum boost voltage
// [R13] Slew rate held separately per channel
// [R14] Top bits 100 software, 011 boost
// [R15] Frequency code 11 keeps default divider
module sw_boost_ctrl #(
	parameter int WDOG_TIMEOUT_US = boost_pkg::WDOG_TIMEOUT_US_DFLT
) (
	// Clock and reset
	input  wire logic        mclk_in,
	input  wire logic        reset_in,
	// Command words from the serial port
	input  wire logic        wr_valid_in,
	input  wire logic [15:0] wr_data_in,
	// Slew rate words, channel chosen by the serial address
	input  wire logic        slew_wr_in,
	input  wire logic [1:0]  slew_chan_in,
	// Watchdog
	input  wire logic        wdog_en_in,
	output logic             alert_out,
	// Software command results
	output logic             crc_check_enable_out,
	output logic             soft_reset_out,
	// Boost converter settings
	output logic             boost_comp_select_out,
	output logic [1:0]       boost_phase_select_out,
	output logic [1:0]       boost_freq_select_out,
	output logic [1:0]       boost_limit_select_out,
	output logic [8:0]       boost_limit_dv_out,
	output logic [15:0]      boost_reg_out,
	output logic [3:0]       boost_clk_out,
	// Slew rate settings
	output logic [3:0]       slew_en_out,
	output logic [27:0]      slew_cfg_out
);

	localparam int         WDOG_CYCLES_I = WDOG_TIMEOUT_US * boost_pkg::US_CYCLES;
	localparam logic [31:0] WDOG_CYCLES  = 32'(WDOG_CYCLES_I);

	boost_cfg_if cfg ();

	logic                 sw_wr;
	logic                 boost_wr;
	logic                 soft_hit;
	logic                 keepalive;
	logic                 soft_rst_r;
	logic                 crc_en_r;
	logic [6:0]           boost_r;
	logic [8:0]           limit_dv_r;
	logic [31:0]          wdog_cnt_r;
	logic                 alert_r;
	logic [3:0]           slew_en_r;
	logic [6:0]           slew_cfg_r [4];
	logic [1:0]           phase_code;
	logic [1:0]           freq_code;
	logic [1:0]           limit_code;

	// Maps a frequency code to its divider; the reserved code keeps the default
	function automatic logic [7:0] freq_div(input logic [1:0] code);
		logic [7:0] d;
		d = boost_pkg::DIV_410K;
		if (code == boost_pkg::FREQ_250K) begin // [R11]
			d = boost_pkg::DIV_250K;
		end else if (code == boost_pkg::FREQ_650K) begin
			d = boost_pkg::DIV_650K;
		end else if (code == boost_pkg::FREQ_410K) begin
			d = boost_pkg::DIV_410K;
		end else begin // [R15]
			d = boost_pkg::DIV_410K;
		end
		return d;
	endfunction

	function automatic logic [8:0] limit_dv(input logic [1:0] code);
		logic [8:0] v;
		case (code) // [R12]
			2'h0:    v = boost_pkg::LIMIT_23V0;
			2'h1:    v = boost_pkg::LIMIT_24V5;
			2'h2:    v = boost_pkg::LIMIT_27V0;
			default: v = boost_pkg::LIMIT_29V5;
		endcase
		return v;
	endfunction

	// Routing by the top three bits; anything else is not for this block
	assign sw_wr    = wr_valid_in && wr_data_in[15:boost_pkg::SEL_LSB] == boost_pkg::SEL_SW; // [R14]
	assign boost_wr = wr_valid_in && wr_data_in[15:boost_pkg::SEL_LSB] == boost_pkg::SEL_BOOST; // [R14]
	assign soft_hit  = sw_wr && wr_data_in[11:0] == boost_pkg::SOFT_RESET_CODE; // [R2]
	assign keepalive = sw_wr && wr_data_in[11:0] == boost_pkg::KEEPALIVE_CODE; // [R3]

	// The reset code is acted on one cycle later so the write itself finishes cleanly
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			soft_rst_r <= 1'b0;
		end else begin
			soft_rst_r <= soft_hit; // [R2]
		end
	end

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			crc_en_r <= 1'b0;
		end else if (soft_rst_r) begin // [R2]
			crc_en_r <= 1'b0;
		end else if (sw_wr && !soft_hit) begin
			crc_en_r <= wr_data_in[boost_pkg::CRC_EN_BIT]; // [R1]
		end
	end

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			boost_r <= boost_pkg::BOOST_RESET;
		end else if (soft_rst_r) begin // [R2]
			boost_r <= boost_pkg::BOOST_RESET;
		end else if (boost_wr) begin
			boost_r <= wr_data_in[boost_pkg::BOOST_W-1:0]; // [R5]
		end
	end

	assign phase_code = boost_r[boost_pkg::PHASE_LSB +: 2];
	assign freq_code  = boost_r[boost_pkg::FREQ_LSB +: 2];
	assign limit_code = boost_r[boost_pkg::LIMIT_LSB +: 2];

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			limit_dv_r <= boost_pkg::LIMIT_23V0;
		end else begin
			limit_dv_r <= limit_dv(limit_code); // [R12]
		end
	end

	// Watchdog: counts while enabled, keep-alive restarts it, alert holds until fed, disabled or soft reset
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			wdog_cnt_r <= 32'h0000_0000;
		end else if (soft_rst_r || !wdog_en_in || keepalive) begin // [R3]
			wdog_cnt_r <= 32'h0000_0000;
		end else if (wdog_cnt_r < WDOG_CYCLES) begin
			wdog_cnt_r <= wdog_cnt_r + 32'h0000_0001;
		end
	end

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			alert_r <= 1'b0;
		end else if (soft_rst_r || !wdog_en_in) begin
			alert_r <= 1'b0;
		end else if (!keepalive && wdog_cnt_r == WDOG_CYCLES - 32'h0000_0001) begin // [R4]
			alert_r <= 1'b1;
		end else if (keepalive) begin
			alert_r <= 1'b0;
		end
	end

	// Each channel keeps its own slew word; it serves current and voltage outputs alike
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			slew_en_r <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				slew_cfg_r[i] <= 7'h00;
			end
		end else if (soft_rst_r) begin
			slew_en_r <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				slew_cfg_r[i] <= 7'h00;
			end
		end else if (slew_wr_in) begin // [R13]
			slew_en_r[slew_chan_in]  <= wr_data_in[boost_pkg::SLEW_EN_BIT];
			slew_cfg_r[slew_chan_in] <= wr_data_in[boost_pkg::SLEW_CFG_W-1:0];
		end
	end

	assign cfg.phase = boost_pkg::boost_phase_e'(phase_code); // [R7]
	assign cfg.div   = freq_div(freq_code); // [R11]

	boost_phase_gen u_phase_gen (
		.mclk_in  (mclk_in),
		.reset_in (reset_in),
		.cfg      (cfg)
	);

	assign alert_out              = alert_r;
	assign crc_check_enable_out   = crc_en_r;
	assign soft_reset_out         = soft_rst_r;
	assign boost_comp_select_out  = boost_r[boost_pkg::COMP_BIT]; // [R6]
	assign boost_phase_select_out = phase_code;
	assign boost_freq_select_out  = freq_code;
	assign boost_limit_select_out = limit_code;
	assign boost_limit_dv_out     = limit_dv_r;
	assign boost_reg_out          = {boost_pkg::SEL_BOOST, 6'h00, boost_r};
	assign boost_clk_out          = cfg.clk;
	assign slew_en_out            = slew_en_r;
	assign slew_cfg_out           = {slew_cfg_r[3], slew_cfg_r[2], slew_cfg_r[1], slew_cfg_r[0]};

	chk_crc_enable_write: assert property (@(posedge mclk_in) disable iff (reset_in) // [R1]
		(sw_wr && !soft_hit && !soft_rst_r)
		|=> (crc_check_enable_out == $past(wr_data_in[boost_pkg::CRC_EN_BIT])))
		else $error("crc enable does not follow bit 12");

	chk_soft_reset_seq: assert property (@(posedge mclk_in) disable iff (reset_in) // [R2]
		soft_hit |=> soft_reset_out ##1
		(!crc_check_enable_out && boost_reg_out[6:0] == boost_pkg::BOOST_RESET && !alert_out))
		else $error("soft reset code did not reset the block");

	chk_keepalive_clears: assert property (@(posedge mclk_in) disable iff (reset_in) // [R3]
		(keepalive && !soft_rst_r) |=> (!alert_out && wdog_cnt_r == 32'h0000_0000))
		else $error("keep-alive did not restart the watchdog");

	chk_wdog_alert_set: assert property (@(posedge mclk_in) disable iff (reset_in) // [R4]
		(wdog_en_in && !soft_rst_r && !keepalive && wdog_cnt_r == WDOG_CYCLES - 32'h0000_0001)
		|=> alert_out)
		else $error("watchdog timeout did not raise alert");

	chk_alert_cause: assert property (@(posedge mclk_in) disable iff (reset_in) // [R4]
		$rose(alert_out) |-> $past(wdog_en_in) && $past(wdog_cnt_r) == WDOG_CYCLES - 32'h0000_0001)
		else $error("alert raised without a timeout");

	chk_boost_fields: assert property (@(posedge mclk_in) disable iff (reset_in) // [R5]
		(boost_wr && !soft_rst_r)
		|=> (boost_comp_select_out == $past(wr_data_in[6]) && boost_phase_select_out == $past(wr_data_in[5:4])
		&& boost_freq_select_out == $past(wr_data_in[3:2]) && boost_limit_select_out == $past(wr_data_in[1:0])))
		else $error("boost fields misplaced");

	chk_limit_map: assert property (@(posedge mclk_in) disable iff (reset_in) // [R12]
		(boost_limit_select_out == 2'h1 && $stable(boost_limit_select_out)) |-> (boost_limit_dv_out == 9'h0f5))
		else $error("limit code 01 does not give 24.5 V");

	chk_freq_reserved: assert property (@(posedge mclk_in) disable iff (reset_in) // [R15]
		(boost_freq_select_out == 2'h3) |-> (cfg.div == boost_pkg::DIV_410K))
		else $error("reserved frequency code changed the divider");

	chk_slew_channel: assert property (@(posedge mclk_in) disable iff (reset_in) // [R13]
		(slew_wr_in && !soft_rst_r)
		|=> (slew_en_out[$past(slew_chan_in)] == $past(wr_data_in[12])))
		else $error("slew enable not stored for its channel");

	chk_foreign_write: assert property (@(posedge mclk_in) disable iff (reset_in) // [R14]
		(wr_valid_in && !sw_wr && !boost_wr && !soft_rst_r)
		|=> ($stable(boost_reg_out) && $stable(crc_check_enable_out)))
		else $error("foreign command changed a register");

	// Value checks written against the fixed encodings rather than the lookup functions
	chk_crc_disable: assert property (@(posedge mclk_in) disable iff (reset_in) // [R1]
		(sw_wr && !soft_hit && !soft_rst_r && !wr_data_in[12]) |=> !crc_check_enable_out)
		else $error("crc enable not cleared by bit 12 low");

	chk_soft_reset_cause: assert property (@(posedge mclk_in) disable iff (reset_in) // [R2]
		soft_reset_out |-> $past(soft_hit))
		else $error("soft reset pulse without reset code");

	chk_wdog_off_quiet: assert property (@(posedge mclk_in) disable iff (reset_in) // [R4]
		!wdog_en_in |=> !alert_out)
		else $error("alert raised with watchdog disabled");

	chk_comp_bypass: assert property (@(posedge mclk_in) disable iff (reset_in) // [R6]
		(boost_wr && !soft_rst_r && wr_data_in[6]) |=> boost_comp_select_out)
		else $error("comp bit 1 did not select bypass");

	chk_phase_route: assert property (@(posedge mclk_in) disable iff (reset_in) // [R7]
		(boost_wr && !soft_rst_r) |=> (cfg.phase == boost_pkg::boost_phase_e'($past(wr_data_in[5:4]))))
		else $error("phase code not passed to the generator");

	chk_freq_div_map: assert property (@(posedge mclk_in) disable iff (reset_in) // [R11]
		(boost_freq_select_out == 2'h0 && cfg.div == 8'ha0) || (boost_freq_select_out == 2'h2 && cfg.div == 8'h3c)
		|| (boost_freq_select_out[0] && cfg.div == 8'h60))
		else $error("frequency code gives wrong divider");

	chk_limit_23v: assert property (@(posedge mclk_in) disable iff (reset_in) // [R12]
		(boost_limit_select_out == 2'h0 && $stable(boost_limit_select_out)) |-> (boost_limit_dv_out == 9'h0e6))
		else $error("limit code 00 does not give 23 V");

	chk_limit_29v5: assert property (@(posedge mclk_in) disable iff (reset_in) // [R12]
		(boost_limit_select_out == 2'h3 && $stable(boost_limit_select_out)) |-> (boost_limit_dv_out == 9'h127))
		else $error("limit code 11 does not give 29.5 V");

endmodule

// ==== sim/host_model.sv ====
// Host model: issues command words, slew words and the watchdog enable.
// Assumes it shares mclk_in with the block and drives 2 ns after each rising edge.
module host_model (
	// Clock
	input  wire logic   mclk_in,
	// Command and slew words
	output logic        wr_valid_out,
	output logic [15:0] wr_data_out,
	output logic        slew_wr_out,
	output logic [1:0]  slew_chan_out,
	// Watchdog enable
	output logic        wdog_en_out
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		wr_valid_out = 1'b0;
		wr_data_out = 16'h0000;
		slew_wr_out = 1'b0;
		slew_chan_out = 2'h0;
		wdog_en_out = 1'b0;
	end

	// Data is not held after a word; inverting it exposes a late sample
	task automatic put(input logic slew, input logic [1:0] chan, input logic [15:0] w);
		@(posedge mclk_in);
		#2;
		wr_valid_out = !slew;
		slew_wr_out = slew;
		slew_chan_out = chan;
		wr_data_out = w;
		@(posedge mclk_in);
		#2;
		wr_valid_out = 1'b0;
		slew_wr_out = 1'b0;
		wr_data_out = ~w;
	endtask

	task automatic send(input logic [15:0] w);
		put(1'b0, 2'h0, w);
	endtask

	task automatic keep_alive();
		send(16'h8195);
	endtask

	task automatic set_wdog(input logic en);
		@(posedge mclk_in);
		#2;
		wdog_en_out = en;
	endtask
endmodule

// ==== sim/sw_boost_ctrl_bench.sv ====
// Self-checking bench for the software command and boost control block.
// Assumes a 40 MHz clock and a shortened watchdog of 80 cycles.
module sw_boost_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {
		logic [15:0] data;
		logic [15:0] reg_v;
		logic        crc;
		logic [8:0]  dv;
	} row_s;

	logic        mclk_in;
	logic        reset_in;
	logic        wr_valid;
	logic [15:0] wr_data;
	logic        slew_wr;
	logic [1:0]  slew_chan;
	logic        wdog_en;
	logic        alert;
	logic        crc_en;
	logic        soft_rst;
	logic        comp;
	logic [1:0]  phase;
	logic [1:0]  freq;
	logic [1:0]  limit;
	logic [8:0]  dv;
	logic [15:0] reg_v;
	logic [3:0]  bclk;
	logic [3:0]  slew_en;
	logic [27:0] slew_cfg;
	int          n_errors;
	int          checks_done;
	int          d1, d2, d3, n;

	row_s rows [8] = '{
		'{16'h6035, 16'h6035, 1'b0, 9'd245}, '{16'h7fc5, 16'h6045, 1'b0, 9'd245},
		'{16'h601a, 16'h601a, 1'b0, 9'd270}, '{16'h602f, 16'h602f, 1'b0, 9'd295},
		'{16'h9000, 16'h602f, 1'b1, 9'd295}, '{16'ha040, 16'h602f, 1'b1, 9'd295},
		'{16'h8000, 16'h602f, 1'b0, 9'd295}, '{16'h6040, 16'h6040, 1'b0, 9'd230}
	};
	int ph_exp [4][3] = '{'{0, 0, 0}, '{0, 192, 192}, '{192, 0, 192}, '{96, 192, 96}};
	int per_exp [4] = '{160, 96, 60, 96};

	host_model host_u (
		.mclk_in       (mclk_in),
		.wr_valid_out  (wr_valid),
		.wr_data_out   (wr_data),
		.slew_wr_out   (slew_wr),
		.slew_chan_out (slew_chan),
		.wdog_en_out   (wdog_en)
	);

	sw_boost_ctrl #(.WDOG_TIMEOUT_US(2)) dut_u (
		.mclk_in                (mclk_in),
		.reset_in               (reset_in),
		.wr_valid_in            (wr_valid),
		.wr_data_in             (wr_data),
		.slew_wr_in             (slew_wr),
		.slew_chan_in           (slew_chan),
		.wdog_en_in             (wdog_en),
		.alert_out              (alert),
		.crc_check_enable_out   (crc_en),
		.soft_reset_out         (soft_rst),
		.boost_comp_select_out  (comp),
		.boost_phase_select_out (phase),
		.boost_freq_select_out  (freq),
		.boost_limit_select_out (limit),
		.boost_limit_dv_out     (dv),
		.boost_reg_out          (reg_v),
		.boost_clk_out          (bclk),
		.slew_en_out            (slew_en),
		.slew_cfg_out           (slew_cfg)
	);

	initial begin
		mclk_in = 1'b0;
		forever #12.5 mclk_in = ~mclk_in;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge mclk_in);
		#2;
	endtask

	task automatic complete_run();
		if (n_errors == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Cycles until the next rising edge of channel A's switching clock
	task automatic wait_rise(output int cnt);
		logic p;
		p = bclk[0];
		for (cnt = 0; cnt < 400 && !(p === 1'b0 && bclk[0] === 1'b1); cnt++) begin
			p = bclk[0];
			tick(1);
		end
		if (cnt == 400) begin
			n_errors++;
			complete_run();
		end
	endtask

	initial begin
		n_errors = 0;
		checks_done = 0;
		reset_in = 1'b1;
		tick(16);
		reset_in = 1'b0;
		chk("reset readback", 16'h6004, reg_v);
		chk("reset freq", 2'h1, freq);
		chk("reset limit", 9'd230, dv);
		chk("reset comp", 1'b0, comp);
		chk("reset alert", 1'b0, alert);
		foreach (rows[i]) begin
			host_u.send(rows[i].data);
			chk("readback", rows[i].reg_v, reg_v);
			chk("comp", rows[i].reg_v[6], comp);
			chk("phase", rows[i].reg_v[5:4], phase);
			chk("freq", rows[i].reg_v[3:2], freq);
			chk("limit", rows[i].reg_v[1:0], limit);
			chk("crc enable", rows[i].crc, crc_en);
			tick(1);
			chk("limit dv", rows[i].dv, dv);
		end
		// Two periods at 96 cycles make the difference counts exact
		for (int p = 0; p < 4; p++) begin
			host_u.send(16'h6004 | 16'(p << 4));
			tick(200);
			d1 = 0;
			d2 = 0;
			d3 = 0;
			repeat (192) begin
				tick(1);
				d1 += int'(bclk[1] !== bclk[0]);
				d2 += int'(bclk[2] !== bclk[0]);
				d3 += int'(bclk[3] !== bclk[0]);
			end
			chk("phase b", ph_exp[p][0], d1);
			chk("phase c", ph_exp[p][1], d2);
			chk("phase d", ph_exp[p][2], d3);
		end
		for (int f = 0; f < 4; f++) begin
			host_u.send(16'h6000 | 16'(f << 2));
			tick(200);
			wait_rise(n);
			wait_rise(n);
			chk("period", per_exp[f], n);
		end
		chk("reserved freq kept", 2'h3, freq);
		host_u.set_wdog(1'b1);
		tick(70);
		chk("alert early", 1'b0, alert);
		tick(20);
		chk("alert late", 1'b1, alert);
		host_u.keep_alive();
		tick(1);
		chk("alert cleared", 1'b0, alert);
		repeat (3) begin
			tick(60);
			host_u.keep_alive();
		end
		tick(30);
		chk("alert fed", 1'b0, alert);
		host_u.set_wdog(1'b0);
		host_u.send(16'h6035);
		host_u.put(1'b1, 2'h2, 16'h1015);
		chk("slew en", 4'h4, slew_en);
		chk("slew cfg", 7'h15, slew_cfg[20:14]);
		host_u.put(1'b1, 2'h0, 16'h0023);
		chk("slew a cfg", 7'h23, slew_cfg[6:0]);
		chk("slew en kept", 4'h4, slew_en);
		host_u.send(16'h9555);
		chk("soft reset pulse", 1'b1, soft_rst);
		tick(1);
		chk("soft reset word", 16'h6004, reg_v);
		chk("soft reset crc", 1'b0, crc_en);
		chk("soft reset slew", 4'h0, slew_en);
		chk("soft reset end", 1'b0, soft_rst);
		host_u.send(16'h6035);
		reset_in = 1'b1;
		#5;
		chk("async reset", 16'h6004, reg_v);
		tick(3);
		reset_in = 1'b0;
		tick(1);
		chk("rereset word", 16'h6004, reg_v);
		chk("rereset dv", 9'd230, dv);
		complete_run();
	end
endmodule
